// >>> rxfh_report.sv
// Purpose: per-frame header status and byte count report for the receiver
// Assumes: receive path, queue read path and register port share mclk_i
// Notes:   headers wait in a small queue until the frame is released
//
// How it works
// R1: each counted frame has one status word that the host may read.
// R2: the valid bit is set only while a completed frame heads the queue.
// R3: checksum errors show as icmp bit 13, ip 12, tcp 11 and udp 10.
// R4: bit 7 marks a broadcast destination.
// R5: bit 6 marks a group destination, broadcast included.
// R6: bit 5 marks an individual destination.
// R7: bit 4 marks a symbol error seen at any time during the frame.
// R8: bit 3 marks a type field above 1500, clear for a length field.
// R9: bit 2 marks frames over 2000 bytes, kept only with pass bad frame.
// R10: an oversize frame is never cut; counting and storing go on. Here the count stops at BC_MAX (4095).
// R11: bit 1 marks runts, kept only with pass bad frame.
// R12: bit 0 marks a check sequence error, kept only with pass bad frame.
// R13: the byte count sits in bits 11-0, the top four bits read zero.
// R14: each counted frame has one byte count that the host may read.
// R15: status and count always describe the same oldest pending frame.
`timescale 1ns/1ps
module rxfh_report
   import rxfh_pkg::*;
#(
   parameter int          HDR_DEPTH = 8,
   parameter logic [11:0] MAX_LEN   = MAX_FRAME_LEN,
   parameter logic [11:0] COLL_WIN  = COLL_WINDOW_LEN,
   parameter int          AW        = $clog2(HDR_DEPTH)
)(
   input  wire logic                 mclk_i,
   input  wire logic                 reset_n_i,
   // receive path
   input  wire logic                 rx_sof_i,
   input  wire logic                 rx_byte_valid_i,
   input  wire logic [7:0]           rx_byte_i,
   input  wire logic                 rx_eof_i,
   input  wire logic                 rx_sym_err_i,
   input  wire logic                 rx_collision_i,
   input  wire logic                 rx_crc_err_i,
   input  wire rxfh_csum_err_s       rx_csum_err_i,
   input  wire logic                 pass_bad_frame_i,
   // queue write path
   output wire logic                 frame_commit_o,
   output wire logic                 frame_discard_o,
   output wire logic                 hdr_overflow_o,
   // queue read path
   input  wire logic                 rx_frame_release_i,
   output wire logic [AW:0]          rx_frame_counter_o,
   output wire logic                 rx_busy_o,
   // register port
   input  wire logic                 reg_rd_i,
   input  wire logic [7:0]           reg_addr_i,
   output wire logic [15:0]          reg_rdata_o,
   output wire logic                 reg_rvalid_o
);

   rxfh_state_e       state_q;
   rxfh_state_e       state_d;
   logic [11:0]       count_q;
   logic [11:0]       count_d;
   logic [47:0]       dest_q;
   logic [47:0]       dest_d;
   logic [15:0]       len_q;
   logic [15:0]       len_d;
   logic              sym_err_q;
   logic              coll_q;
   logic              crc_err_q;
   rxfh_csum_err_s    csum_q;
   logic [AW-1:0]     wr_ptr_q;
   logic [AW-1:0]     rd_ptr_q;
   logic [AW:0]       fill_q;
   logic [15:0]       rdata_q;
   logic              rvalid_q;
   rxfh_hdr_s         mem_q [HDR_DEPTH];

   wire logic         in_recv;
   wire logic         in_done;
   wire logic         take_byte;
   wire logic         count_full;
   wire logic [11:0]  count_inc;
   wire logic         bcast;
   wire logic         mcast;
   wire logic         ucast;
   wire logic         ethertype;
   wire logic         oversize;
   wire logic         runt;
   wire logic         bad_frame;
   wire logic         keep;
   wire logic         q_full;
   wire logic         q_empty;
   wire logic         push;
   wire logic         pop;
   wire logic [15:0]  new_status;
   wire rxfh_hdr_s    new_hdr;
   wire rxfh_hdr_s    head_hdr;
   wire logic [15:0]  head_status;
   wire logic [15:0]  head_count;
   wire logic         sel_status;
   wire logic         sel_count;
   wire logic         sel_hi;
   wire logic [15:0]  sel_word;
   wire logic [15:0]  rd_word;

   assign in_recv    = state_q == RXFH_RECV;
   assign in_done    = state_q == RXFH_DONE;
   assign take_byte  = in_recv & rx_byte_valid_i;
   assign count_full = count_q == BC_MAX;
   // R10: saturate rather than wrap
   assign count_inc  = count_full ? count_q : count_q + 12'h001;

   rxfh_addr_class u_addr_class (
      .dest_i  (dest_q),
      .bcast_o (bcast),
      .mcast_o (mcast),
      .ucast_o (ucast)
   );

   rxfh_len_check #(
      .MAX_LEN  (MAX_LEN),
      .COLL_WIN (COLL_WIN)
   ) u_len_check (
      .byte_count_i (count_q),
      .len_type_i   (len_q),
      .collision_i  (coll_q),
      .ethertype_o  (ethertype),
      .oversize_o   (oversize),
      .runt_o       (runt)
   );

   // frame capture sequence
   always_comb begin
      state_d = state_q;
      case (state_q)
         RXFH_IDLE: begin
            if (rx_sof_i) begin
               state_d = RXFH_RECV;
            end
         end
         RXFH_RECV: begin
            if (rx_eof_i) begin
               state_d = RXFH_DONE;
            end
         end
         RXFH_DONE: begin
            state_d = RXFH_IDLE;
         end
         default: begin
            state_d = RXFH_IDLE;
         end
      endcase
   end

   // R10: count bytes until the count saturates at BC_MAX, nothing is cut
   assign count_d = (state_q == RXFH_IDLE) ? 12'h000 :
                    take_byte ? count_inc : count_q;

   // destination bytes shift in during the first six bytes
   assign dest_d = (take_byte && count_q <= DEST_LAST_IDX) ?
                   {dest_q[39:0], rx_byte_i} : dest_q;

   assign len_d = (take_byte && count_q == LEN_HI_IDX) ?
                     {rx_byte_i, len_q[7:0]} :
                  (take_byte && count_q == LEN_LO_IDX) ?
                     {len_q[15:8], rx_byte_i} : len_q;

   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state_q <= RXFH_IDLE;
         count_q <= 12'h000;
         dest_q  <= DEST_RST;
         len_q   <= LEN_RST;
      end else begin
         state_q <= state_d;
         count_q <= count_d;
         dest_q  <= (state_q == RXFH_IDLE) ? DEST_RST : dest_d;
         len_q   <= (state_q == RXFH_IDLE) ? LEN_RST : len_d;
      end
   end

   // R7: symbol error is sticky over the frame
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         sym_err_q <= 1'b0;
         coll_q    <= 1'b0;
      end else if (rx_sof_i && state_q == RXFH_IDLE) begin
         sym_err_q <= 1'b0;
         coll_q    <= 1'b0;
      end else if (in_recv) begin
         sym_err_q <= sym_err_q | rx_sym_err_i;
         coll_q    <= coll_q | rx_collision_i;
      end
   end

   // checksum and check sequence results arrive with the end marker
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         crc_err_q <= 1'b0;
         csum_q    <= '0;
      end else if (in_recv && rx_eof_i) begin
         crc_err_q <= rx_crc_err_i;
         csum_q    <= rx_csum_err_i;
      end
   end

   // R9: oversize dropped unless passing bad frames
   // R11: runt dropped unless passing bad frames
   // R12: crc error dropped unless passing bad frames
   assign bad_frame = oversize | runt | crc_err_q;
   assign keep      = ~bad_frame | pass_bad_frame_i;

   // R3: checksum error bits
   // R4: broadcast bit
   // R5: multicast bit
   // R6: unicast bit
   // R8: frame type bit
   assign new_status = {1'b0,
                        1'b0,
                        csum_q.icmp,
                        csum_q.ip,
                        csum_q.tcp,
                        csum_q.udp,
                        2'b00,
                        bcast,
                        mcast,
                        ucast,
                        sym_err_q,
                        ethertype,
                        oversize,
                        runt,
                        crc_err_q};

   // R15: status and count stored as one entry
   assign new_hdr.status = new_status;
   assign new_hdr.count  = count_q;

   assign q_full  = fill_q == (AW+1)'(HDR_DEPTH);
   assign q_empty = fill_q == (AW+1)'(0);
   // a full header queue loses the new frame, never an older one
   assign push    = in_done & keep & ~q_full;
   // R1: one release per counted frame
   assign pop     = rx_frame_release_i & ~q_empty;

   assign frame_commit_o  = push;
   assign frame_discard_o = in_done & ~push;
   assign hdr_overflow_o  = in_done & keep & q_full;
   assign rx_busy_o       = in_recv | in_done;
   // R14: counter matches stored headers
   assign rx_frame_counter_o = fill_q;

   always_ff @(posedge mclk_i) begin
      if (push) begin
         mem_q[wr_ptr_q] <= new_hdr;
      end
   end

   // simultaneous push and pop leave the fill level alone
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         fill_q   <= '0;
      end else begin
         if (push) begin
            wr_ptr_q <= (wr_ptr_q == AW'(HDR_DEPTH - 1)) ? '0 :
                        wr_ptr_q + AW'(1);
         end
         if (pop) begin
            rd_ptr_q <= (rd_ptr_q == AW'(HDR_DEPTH - 1)) ? '0 :
                        rd_ptr_q + AW'(1);
         end
         if (push && !pop) begin
            fill_q <= fill_q + (AW+1)'(1);
         end else if (pop && !push) begin
            fill_q <= fill_q - (AW+1)'(1);
         end
      end
   end

   // R15: both registers read the same head entry
   assign head_hdr    = mem_q[rd_ptr_q];
   // R2: valid only with a finished frame at the head
   assign head_status = q_empty ? 16'h0000 :
                        {1'b1, head_hdr.status[ST_VALID_BIT-1:0]};
   // R13: upper four bits read zero
   assign head_count  = q_empty ? 16'h0000 : {4'h0, head_hdr.count};

   // byte reads of the odd address return the upper byte
   assign sel_status = reg_addr_i[7:1] == RXFH_STATUS_OFS[7:1];
   assign sel_count  = reg_addr_i[7:1] == RXFH_COUNT_OFS[7:1];
   assign sel_hi     = reg_addr_i[0];
   assign sel_word   = sel_status ? head_status :
                       sel_count  ? head_count  : 16'h0000;
   assign rd_word    = sel_hi ? {8'h00, sel_word[15:8]} : sel_word;

   // reads have no side effect; release comes from the queue read path
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rdata_q  <= RDATA_RST;
         rvalid_q <= 1'b0;
      end else begin
         rvalid_q <= reg_rd_i;
         if (reg_rd_i) begin
            rdata_q <= rd_word;
         end
      end
   end

   assign reg_rdata_o  = rdata_q;
   assign reg_rvalid_o = rvalid_q;

endmodule

// >>> rxfh_pkg.sv
// Purpose: shared constants and carriers for the receive frame header report
// Assumes: one core clock; receive path and register port on that clock
// Notes:   offsets are byte addresses on the serial register port
package rxfh_pkg;

   // register map
   localparam logic [7:0]  RXFH_STATUS_OFS     = 8'h7C;
   localparam logic [7:0]  RXFH_COUNT_OFS      = 8'h7E;

   // status word field positions
   localparam int          ST_VALID_BIT        = 15;
   localparam int          ST_ICMP_BIT         = 13;
   localparam int          ST_IP_BIT           = 12;
   localparam int          ST_TCP_BIT          = 11;
   localparam int          ST_UDP_BIT          = 10;
   localparam int          ST_BCAST_BIT        = 7;
   localparam int          ST_MCAST_BIT        = 6;
   localparam int          ST_UCAST_BIT        = 5;
   localparam int          ST_SYMERR_BIT       = 4;
   localparam int          ST_ETYPE_BIT        = 3;
   localparam int          ST_LONG_BIT         = 2;
   localparam int          ST_RUNT_BIT         = 1;
   localparam int          ST_CRC_BIT          = 0;

   // byte count field
   localparam int          BC_WIDTH            = 12;
   localparam logic [11:0] BC_MAX              = 12'hFFF;

   // frame length limits, in bytes
   localparam logic [15:0] ETYPE_MIN_LEN       = 16'h05DC;
   localparam logic [11:0] MAX_FRAME_LEN       = 12'h7D0;
   localparam logic [11:0] COLL_WINDOW_LEN     = 12'h040;

   // byte positions inside the frame
   localparam logic [11:0] DEST_LAST_IDX       = 12'h005;
   localparam logic [11:0] LEN_HI_IDX          = 12'h00C;
   localparam logic [11:0] LEN_LO_IDX          = 12'h00D;

   // reset values
   localparam logic [15:0] RDATA_RST           = 16'h0000;
   localparam logic [47:0] DEST_RST            = 48'h000000000000;
   localparam logic [15:0] LEN_RST             = 16'h0000;

   typedef struct packed {
      logic icmp;
      logic ip;
      logic tcp;
      logic udp;
   } rxfh_csum_err_s;

   typedef struct packed {
      logic [15:0] status;
      logic [11:0] count;
   } rxfh_hdr_s;

   typedef enum logic [1:0] {
      RXFH_IDLE = 2'b00,
      RXFH_RECV = 2'b01,
      RXFH_DONE = 2'b10
   } rxfh_state_e;

endpackage

// >>> rxfh_addr_class.sv
// Purpose: classifies a destination address as broadcast, multicast, unicast
// Assumes: address bytes in wire order, first byte in bits 47:40
// Notes:   group bit is the lsb of the first byte on the wire
`timescale 1ns/1ps
module rxfh_addr_class
   import rxfh_pkg::*;
(
   input  wire logic [47:0] dest_i,
   output wire logic        bcast_o,
   output wire logic        mcast_o,
   output wire logic        ucast_o
);

   wire logic group_bit;

   assign group_bit = dest_i[40];
   // R4: all ones address
   assign bcast_o   = &dest_i;
   // R5: broadcast counts as group
   assign mcast_o   = group_bit;
   // R6: individual address
   assign ucast_o   = ~group_bit;

endmodule

// >>> rxfh_len_check.sv
// Purpose: length based frame classification
// Assumes: byte count covers every byte handed over, check sequence included
// Notes:   type flag is meaningless for runts; caller still reports it
`timescale 1ns/1ps
module rxfh_len_check
   import rxfh_pkg::*;
#(
   parameter logic [11:0] MAX_LEN  = MAX_FRAME_LEN,
   parameter logic [11:0] COLL_WIN = COLL_WINDOW_LEN
)(
   input  wire logic [11:0] byte_count_i,
   input  wire logic [15:0] len_type_i,
   input  wire logic        collision_i,
   output wire logic        ethertype_o,
   output wire logic        oversize_o,
   output wire logic        runt_o
);

   // R8: type field above length range
   assign ethertype_o = len_type_i > ETYPE_MIN_LEN;
   // R9: longer than the maximum
   assign oversize_o  = byte_count_i > MAX_LEN;
   // R11: collision or early end
   assign runt_o      = collision_i | (byte_count_i < COLL_WIN);

endmodule

// >>> rxfh_report_props.sv
// Purpose: port level checks for the frame header report
// Assumes: single clock, async active low reset
// Notes:   status reads are judged against the queued header count
`timescale 1ns/1ps
module rxfh_report_props
   import rxfh_pkg::*;
#(
   parameter int HDR_DEPTH = 8,
   parameter int AW        = $clog2(HDR_DEPTH)
)(
   input wire logic        mclk_i,
   input wire logic        reset_n_i,
   input wire logic        rx_eof_i,
   input wire logic        pass_bad_frame_i,
   input wire logic        frame_commit_o,
   input wire logic        frame_discard_o,
   input wire logic        hdr_overflow_o,
   input wire logic        rx_frame_release_i,
   input wire logic [AW:0] rx_frame_counter_o,
   input wire logic        rx_busy_o,
   input wire logic        reg_rd_i,
   input wire logic [7:0]  reg_addr_i,
   input wire logic [15:0] reg_rdata_o,
   input wire logic        reg_rvalid_o
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!reset_n_i);
   wire st_rd = reg_rd_i && reg_addr_i == RXFH_STATUS_OFS;
   wire bc_rd = reg_rd_i && reg_addr_i == RXFH_COUNT_OFS;
   rvalid_lat_a: assert property (reg_rd_i |=> reg_rvalid_o)
      else $error("read answer late");
   rvalid_cause_a: assert property (reg_rvalid_o |-> $past(reg_rd_i))
      else $error("read answer without read");
   valid_flag_a: assert property (st_rd |=>
      reg_rdata_o[15] == ($past(rx_frame_counter_o) != 0))
      else $error("valid bit disagrees with queue");
   resv_zero_a: assert property (st_rd |=>
      !reg_rdata_o[14] && reg_rdata_o[9:8] == 2'h0)
      else $error("reserved status bits set");
   count_top_a: assert property (bc_rd |=> reg_rdata_o[15:12] == 4'h0)
      else $error("byte count upper bits set");
   bcast_mcast_a: assert property (st_rd |=>
      !reg_rdata_o[7] || reg_rdata_o[6])
      else $error("broadcast without multicast");
   class_excl_a: assert property (st_rd ##1 reg_rdata_o[15] |->
      reg_rdata_o[6] ^ reg_rdata_o[5])
      else $error("address class not exclusive");
   decide_lat_a: assert property (rx_eof_i && rx_busy_o |=>
      frame_commit_o ^ frame_discard_o)
      else $error("no single verdict after frame end");
   pass_keep_a: assert property (frame_discard_o && pass_bad_frame_i |->
      hdr_overflow_o)
      else $error("frame dropped despite pass bad frame");
   count_up_a: assert property (frame_commit_o && !rx_frame_release_i |=>
      rx_frame_counter_o == $past(rx_frame_counter_o) + 1'b1)
      else $error("frame counter not advanced");
   count_dn_a: assert property (rx_frame_release_i && !frame_commit_o &&
      rx_frame_counter_o != 0 |=>
      rx_frame_counter_o == $past(rx_frame_counter_o) - 1'b1)
      else $error("frame counter not reduced");
   commit_c: cover property (frame_commit_o);
   discard_c: cover property (frame_discard_o);
   valid_rd_c: cover property (st_rd ##1 reg_rdata_o[15]);
endmodule

bind rxfh_report rxfh_report_props #(.HDR_DEPTH(HDR_DEPTH), .AW(AW)) u_props (
   .mclk_i(mclk_i), .reset_n_i(reset_n_i), .rx_eof_i(rx_eof_i),
   .pass_bad_frame_i(pass_bad_frame_i), .frame_commit_o(frame_commit_o),
   .frame_discard_o(frame_discard_o), .hdr_overflow_o(hdr_overflow_o),
   .rx_frame_release_i(rx_frame_release_i),
   .rx_frame_counter_o(rx_frame_counter_o), .rx_busy_o(rx_busy_o),
   .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
   .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o));

// >>> rxfh_host_model.sv
// Purpose: host side of the register port, issues single reads
// Assumes: read strobe sampled on the rising clock edge
// Notes:   address is scrambled while idle so stale values never match
`timescale 1ns/1ps
module rxfh_host_model (
   input  wire logic       mclk_i,
   output logic            reg_rd_o,
   output logic [7:0]      reg_addr_o
);
   initial begin
      reg_rd_o = 1'b0;
      reg_addr_o = 8'h00;
   end
   task automatic rd(input logic [7:0] a);
      @(posedge mclk_i) #1;
      reg_rd_o = 1'b1;
      reg_addr_o = a;
      @(posedge mclk_i) #1;
      reg_rd_o = 1'b0;
      reg_addr_o = ~a;
   endtask
endmodule

// >>> rxfh_report_tb.sv
// Purpose: self checking bench for the frame header report
// Assumes: design default depth of eight headers
// Notes:   register answers are compared by a watcher against a queue
`timescale 1ns/1ps
module rxfh_report_tb;
   import rxfh_pkg::*;
   logic mclk_i, reset_n_i, sof, bv, eof, sym, col, crc, pass, rel;
   logic [7:0] byt;
   rxfh_csum_err_s cs;
   logic cm, dc, ov, busy, rv, rd;
   logic [3:0] cnt;
   logic [7:0] addr;
   logic [15:0] rdat;
   logic [15:0] exp_q[$];
   logic [31:0] seed = 32'd79;
   int n_errors = 0, samples_checked = 0, cycles = 0, queued = 0;
   logic hold = 1'b0;
   logic [15:0] held_q[$];
   rxfh_report uut (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
      .rx_sof_i(sof), .rx_byte_valid_i(bv), .rx_byte_i(byt),
      .rx_eof_i(eof), .rx_sym_err_i(sym), .rx_collision_i(col),
      .rx_crc_err_i(crc), .rx_csum_err_i(cs), .pass_bad_frame_i(pass),
      .frame_commit_o(cm), .frame_discard_o(dc), .hdr_overflow_o(ov),
      .rx_frame_release_i(rel), .rx_frame_counter_o(cnt),
      .rx_busy_o(busy), .reg_rd_i(rd), .reg_addr_i(addr),
      .reg_rdata_o(rdat), .reg_rvalid_o(rv));
   rxfh_host_model host (.mclk_i(mclk_i), .reg_rd_o(rd), .reg_addr_o(addr));
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic chk(input logic [15:0] seen, input logic [15:0] want);
      samples_checked++;
      if (seen !== want) begin
         n_errors++;
         $display("wrong value at %0t: saw %h want %h", $time, seen, want);
      end
   endtask
   task automatic give_verdict();
      if (n_errors == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial begin
      mclk_i = 1'b0;
      forever #5 mclk_i = ~mclk_i;
   end
   always @(posedge mclk_i) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         give_verdict();
      end
   end
   // watcher: each answer against the oldest note
   always @(negedge mclk_i) begin
      if (rv === 1'b1) begin
         if (exp_q.size() == 0)
            chk(rdat, 16'hDEAD);
         else
            chk(rdat, exp_q.pop_front());
      end
   end
   task automatic rdx(input logic [7:0] a, input logic [15:0] v);
      exp_q.push_back(v);
      host.rd(a);
   endtask
   task automatic frame(input logic [47:0] d, input logic [15:0] lt,
         input int n, input logic s, c, e, p);
      logic [15:0] st;
      logic rn, lg, keep, ovf, cmt;
      lg = n > 2000;
      rn = c || n < 64;
      keep = !(lg || rn || e) || p;
      // a full header queue loses the new frame
      ovf = keep && queued == 8;
      cmt = keep && !ovf;
      pass = p;
      @(posedge mclk_i) #1 sof = 1'b1;
      @(posedge mclk_i) #1 sof = 1'b0;
      for (int i = 0; i < n; i++) begin
         bv = 1'b1;
         byt = i < 6 ? d[47 - 8*i -: 8] : i == 12 ? lt[15:8] :
               i == 13 ? lt[7:0] : 8'(xs());
         sym = s && i == 20;
         col = c && i == 3;
         @(posedge mclk_i) #1;
      end
      bv = 1'b0;
      sym = 1'b0;
      col = 1'b0;
      eof = 1'b1;
      crc = e;
      cs = 4'(xs());
      st = {2'b10, cs, 2'b00, &d, d[40], !d[40], s, lt > 16'd1500, lg,
            rn, e};
      @(posedge mclk_i) #1 eof = 1'b0;
      chk({13'h0, cm, dc, ov}, {13'h0, cmt, !cmt, ovf});
      chk({15'h0, busy}, 16'h0001);
      if (cmt) begin
         queued++;
      end
      @(posedge mclk_i) #1;
      chk({12'h0, cnt}, 16'(queued));
      if (cmt && hold) begin
         held_q.push_back(n[15:0] & 16'h0FFF);
      end
      if (cmt && !hold) begin
         rdx(RXFH_STATUS_OFS, st);
         rdx(RXFH_COUNT_OFS, n[15:0] & 16'h0FFF);
         rdx(8'h7D, {8'h00, st[15:8]});
         rdx(8'h7F, {12'h000, n[11:8]});
         @(posedge mclk_i) #1 rel = 1'b1;
         @(posedge mclk_i) #1 rel = 1'b0;
         queued--;
      end
      if (!hold) begin
         rdx(RXFH_STATUS_OFS, 16'h0000);
         rdx(8'h40, 16'h0000);
      end
   endtask
   initial begin
      {sof, bv, eof, sym, col, crc, pass, rel} = 8'h00;
      byt = 8'h00;
      cs = 4'h0;
      reset_n_i = 1'b0;
      repeat (6) @(posedge mclk_i);
      #1 reset_n_i = 1'b1;
      @(posedge mclk_i) #1;
      rdx(RXFH_COUNT_OFS, 16'h0000);
      frame(48'hFFFFFFFFFFFF, 16'h0800, 64, 0, 0, 0, 0);
      frame({8'h01, xs(), 8'h00}, 16'h05DC, 100, 1, 0, 0, 0);
      frame({8'h02, xs(), 8'h11}, 16'h05DD, 2001, 0, 0, 0, 1);
      frame({8'h00, xs(), 8'h22}, 16'h0800, 2001, 0, 0, 0, 0);
      frame({8'h04, xs(), 8'h33}, 16'h0806, 80, 0, 0, 1, 1);
      frame({8'h06, xs(), 8'h44}, 16'h0806, 80, 0, 0, 1, 0);
      frame({8'h03, xs(), 8'h55}, 16'h0040, 90, 0, 1, 0, 1);
      frame({8'h08, xs(), 8'h66}, 16'h0800, 63, 0, 0, 0, 1);
      frame({8'h0A, xs(), 8'h77}, 16'h0800, 70, 0, 1, 0, 0);
      // fill the header queue, then one more frame overflows it
      hold = 1'b1;
      for (int k = 0; k < 9; k++) begin
         frame({8'h00, xs(), 8'h00}, 16'h0800, 64 + k, 0, 0, 0, 1);
      end
      hold = 1'b0;
      // drain in arrival order, oldest frame first
      for (int k = 0; k < 8; k++) begin
         rdx(RXFH_COUNT_OFS, held_q.pop_front());
         @(posedge mclk_i) #1 rel = 1'b1;
         @(posedge mclk_i) #1 rel = 1'b0;
         queued--;
      end
      @(posedge mclk_i) #1;
      chk({12'h0, cnt}, 16'(queued));
      repeat (3) @(posedge mclk_i);
      chk(16'(exp_q.size()), 16'h0000);
      give_verdict();
   end
endmodule
